// [core/rmul_pkg.sv]
// constants shared by the radio module serial link
package rmul_pkg;
  // link framing and timing
  localparam int unsigned CLK_HZ         = 200_000_000;          // reference clock rate
  localparam int unsigned BAUD_BPS       = 115_200;              // serial bit rate
  localparam int unsigned BIT_CYC        = CLK_HZ / BAUD_BPS;    // cycles per bit, rounded down
  localparam int unsigned HALF_BIT_CYC   = BIT_CYC / 2;          // mid-bit sampling offset
  localparam int unsigned DATA_BITS      = 8;                    // data bits per character
  localparam int unsigned PKT_MAX_BYTES  = 256;                  // longest packet in bytes
  localparam logic [7:0]  NEWLINE_CHAR   = 8'h0a;                // packet delimiter
  // pairing indicator and sleep timing
  localparam int unsigned BLINK_HALF_MS  = 250;                  // blink half period in ms
  localparam int unsigned BLINK_HALF_CYC = BLINK_HALF_MS * (CLK_HZ / 1000);
  localparam int unsigned PAIRING_INDICATOR_WAIT_S    = 60;                   // one minute pairing window
  localparam longint unsigned PAIRING_INDICATOR_WAIT_CYC = 64'(PAIRING_INDICATOR_WAIT_S) * 64'(CLK_HZ);
  // reset values
  localparam logic        LINE_IDLE      = 1'b1;                 // serial line idles high
endpackage : rmul_pkg

// [core/rmul_tx.sv]
// serial character transmitter, 8n1, least significant bit first
`timescale 1ns/10ps
`default_nettype none
module rmul_tx #(
  parameter int unsigned BIT_CYC = rmul_pkg::BIT_CYC  // cycles per bit
) (
  input  wire logic       i_ref_clk,    // reference clock
  input  wire logic       i_rst_b,      // synchronised reset, active low
  input  wire logic       i_valid,      // byte offered
  input  wire logic [7:0] i_data,       // byte to send
  output logic            o_ready,      // idle, byte may be offered
  output logic            o_txd         // serial line out
);
  typedef enum {RMUL_TX_IDLE, RMUL_TX_SHIFT} rmul_tx_e;
  typedef struct packed {
    rmul_tx_e    st;     // state
    logic [15:0] cnt;    // bit timer
    logic [3:0]  idx;    // bit index 0 start .. 9 stop
    logic [9:0]  sh;     // frame shift register
    logic        txd;    // line level
  } rmul_tx_s;
  rmul_tx_s s_q, s_d;

  // next-state logic
  always_comb begin
    s_d = s_q;
    case (s_q.st)
      RMUL_TX_IDLE: begin
        s_d.txd = rmul_pkg::LINE_IDLE;
        if (i_valid) begin
          // start low, data lsb first, stop high, no parity
          s_d.sh  = {1'b1, i_data, 1'b0};
          s_d.idx = 4'h0;
          s_d.cnt = 16'h0;
          s_d.st  = RMUL_TX_SHIFT;
          s_d.txd = 1'b0;
        end
      end
      RMUL_TX_SHIFT: begin
        if (s_q.cnt == 16'(BIT_CYC - 1)) begin
          s_d.cnt = 16'h0;
          if (s_q.idx == 4'h9) begin
            s_d.st  = RMUL_TX_IDLE;
            s_d.txd = rmul_pkg::LINE_IDLE;
          end else begin
            s_d.idx = s_q.idx + 4'h1;
            s_d.txd = s_q.sh[s_q.idx + 4'h1];
          end
        end else begin
          s_d.cnt = s_q.cnt + 16'h1;
        end
      end
      default: s_d.st = RMUL_TX_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '{st: RMUL_TX_IDLE, cnt: 16'h0, idx: 4'h0, sh: 10'h3ff, txd: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_txd   = s_q.txd;
  assign o_ready = (s_q.st == RMUL_TX_IDLE);

  // a frame lasts ten bit times; the line is low during the start bit
  a_tx_start_low : assert property (@(posedge i_ref_clk) disable iff (!i_rst_b)
    (s_q.st == RMUL_TX_IDLE && i_valid) |=> !o_txd [*2])
    else $error("start bit not low");
endmodule // rmul_tx
`default_nettype wire

// [core/rmul_radio.sv]
// radio-side end of the serial link: receive queue, send on newline, pairing
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - two-wire async serial link at 115200 bps
// - packets up to 256 bytes accepted
// - newline ends every packet
// - queue bytes, send over air on newline
// - blink pairing indicator while awaiting pairing
// - indicator steady on once paired
// - no pairing within one minute, deep sleep
// - sleep until wake reset, then resume
module rmul_radio #(
  parameter int unsigned       BIT_CYC    = rmul_pkg::BIT_CYC,        // cycles per bit
  parameter int unsigned       BLINK_CYC  = rmul_pkg::BLINK_HALF_CYC, // blink half period
  parameter longint unsigned   WAIT_CYC   = rmul_pkg::PAIRING_INDICATOR_WAIT_CYC,  // pairing window
  parameter int unsigned       DEPTH      = rmul_pkg::PKT_MAX_BYTES   // queue depth
) (
  input  wire logic       i_ref_clk,            // 200 MHz reference clock
  input  wire logic       i_rst_b,              // board reset, active low, async
  input  wire logic       i_radio_wake_reset,   // wake button, active high level
  input  wire logic       i_rxd,                // serial from logic side
  input  wire logic       i_air_paired,         // over-air peer has paired
  input  wire logic       i_air_rx_valid,       // byte arrived over the air
  input  wire logic [7:0] i_air_rx_data,        // that byte
  output logic            o_txd,                // serial to logic side
  output logic            o_air_tx_valid,       // byte sent over the air
  output logic [7:0]      o_air_tx_data,        // that byte
  output logic            o_air_tx_last,        // marks the newline byte
  output logic            o_pairing_indicator,  // pairing lamp
  output logic            o_sleep               // deep sleep status
);
  localparam int AW = $clog2(DEPTH);
  typedef enum {RMUL_RX_IDLE, RMUL_RX_BITS} rmul_rx_e;
  typedef enum {RMUL_PR_WAIT, RMUL_PR_PAIRED, RMUL_PR_SLEEP} rmul_pr_e;
  typedef struct packed {
    logic [1:0]    rsync;   // reset release pipeline
    logic [1:0]    dsync;   // rxd resampler, stage 1 read only by stage 2
    rmul_rx_e      rst;     // receive state
    logic [15:0]   rcnt;    // bit timer
    logic [3:0]    ridx;    // bit index
    logic [7:0]    rsh;     // received bits
    logic [AW:0]   cnt;     // queue fill count
    logic          drain;   // newline seen, emptying queue
    logic          airv;    // over-air byte strobe
    logic [7:0]    aird;    // over-air byte
    logic          airl;    // over-air last byte
    rmul_pr_e      pst;     // pairing state
    logic [31:0]   bcnt;    // blink timer
    logic [37:0]   wcnt;    // pairing window timer
    logic          lamp;    // indicator level
    logic          sleep;   // sleep level
    logic [DEPTH-1:0][7:0] mem;  // byte queue, flip-flops addressed by index
    logic [AW-1:0] wp;      // queue write index
    logic [AW-1:0] rp;      // queue read index
  } rmul_radio_s;
  rmul_radio_s s_q, s_d;
  logic       rst_b;                  // synchronised reset
  logic       byte_ok;                // full character received
  logic       tx_ready;               // transmitter idle
  logic       tx_fire;                // byte handed to transmitter

  assign rst_b = s_q.rsync[1];

  // bit-time compare used by the receiver in one place
  function automatic logic at_count(input logic [15:0] c, input int unsigned n);
    return c == 16'(n - 1);
  endfunction

  // next-state logic for receiver, queue control and pairing
  always_comb begin
    s_d       = s_q;
    s_d.rsync = {s_q.rsync[0], 1'b1};
    s_d.dsync = {s_q.dsync[0], i_rxd};
    s_d.airv  = 1'b0;
    s_d.airl  = 1'b0;
    byte_ok   = 1'b0;
    // receiver: mid-bit sampling at the link rate
    case (s_q.rst)
      RMUL_RX_IDLE: begin
        if (!s_q.dsync[1] && !s_q.sleep) begin
          s_d.rst  = RMUL_RX_BITS;
          s_d.rcnt = 16'(BIT_CYC / 2);
          s_d.ridx = 4'h0;
        end
      end
      RMUL_RX_BITS: begin
        if (at_count(s_q.rcnt, BIT_CYC)) begin
          s_d.rcnt = 16'h0;
          s_d.ridx = s_q.ridx + 4'h1;
          if (s_q.ridx == 4'h0 && s_q.dsync[1]) begin
            s_d.rst = RMUL_RX_IDLE;             // false start, glitch
          end else if (s_q.ridx == 4'h9) begin
            s_d.rst = RMUL_RX_IDLE;
            byte_ok = s_q.dsync[1];            // stop bit must be high
          end else if (s_q.ridx != 4'h0) begin
            s_d.rsh = {s_q.dsync[1], s_q.rsh[7:1]}; // lsb first
          end
        end else begin
          s_d.rcnt = s_q.rcnt + 16'h1;
        end
      end
      default: s_d.rst = RMUL_RX_IDLE;
    endcase
    // queue drain goes first so that a newline arriving as the old one leaves keeps drain set
    if (s_q.drain && s_q.cnt != '0) begin
      s_d.cnt  = s_d.cnt - (AW+1)'(1);
      s_d.rp   = s_q.rp + AW'(1);
      s_d.airv = 1'b1;
      s_d.aird = s_q.mem[s_q.rp];
      s_d.airl = (s_q.mem[s_q.rp] == rmul_pkg::NEWLINE_CHAR);
      if (s_q.mem[s_q.rp] == rmul_pkg::NEWLINE_CHAR) begin
        s_d.drain = 1'b0;
      end
    end
    // queue fill: hold bytes until newline; a full queue drops further bytes
    if (byte_ok && s_q.cnt != (AW+1)'(DEPTH)) begin
      s_d.cnt         = s_d.cnt + (AW+1)'(1);
      s_d.mem[s_q.wp] = s_q.rsh;
      s_d.wp          = s_q.wp + AW'(1);
      if (s_q.rsh == rmul_pkg::NEWLINE_CHAR) begin
        s_d.drain = 1'b1;
      end
    end
    // pairing indicator and sleep sequencing
    case (s_q.pst)
      RMUL_PR_WAIT: begin
        s_d.sleep = 1'b0;
        if (i_air_paired) begin
          s_d.pst  = RMUL_PR_PAIRED;
          s_d.lamp = 1'b1;
        end else if (s_q.wcnt == 38'(WAIT_CYC - 1)) begin
          s_d.pst   = RMUL_PR_SLEEP;
          s_d.sleep = 1'b1;
          s_d.lamp  = 1'b0;
        end else begin
          s_d.wcnt = s_q.wcnt + 38'h1;
          if (s_q.bcnt == 32'(BLINK_CYC - 1)) begin
            s_d.bcnt = 32'h0;
            s_d.lamp = !s_q.lamp;
          end else begin
            s_d.bcnt = s_q.bcnt + 32'h1;
          end
        end
      end
      RMUL_PR_PAIRED: begin
        s_d.lamp = 1'b1;
        if (!i_air_paired) begin
          s_d.pst  = RMUL_PR_WAIT;              // link lost: ready again
          s_d.wcnt = 38'h0;
          s_d.bcnt = 32'h0;
        end
      end
      RMUL_PR_SLEEP: begin
        s_d.lamp  = 1'b0;
        s_d.sleep = 1'b1;
      end
      default: s_d.pst = RMUL_PR_WAIT;
    endcase
    if (i_radio_wake_reset) begin
      s_d.pst   = RMUL_PR_WAIT;
      s_d.sleep = 1'b0;
      s_d.wcnt  = 38'h0;
      s_d.bcnt  = 32'h0;
      s_d.lamp  = 1'b1;
      s_d.cnt   = '0;
      s_d.drain = 1'b0;
      s_d.wp    = '0;
      s_d.rp    = '0;
    end
  end

  // state register; first reset pipeline stage only sees constants
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q <= '0;
      s_q.dsync <= 2'b11;
      s_q.lamp  <= 1'b1;
    end else if (!rst_b) begin
      s_q       <= '0;
      s_q.rsync <= s_d.rsync;
      s_q.dsync <= 2'b11;
      s_q.lamp  <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // over-the-air receive path passes straight to the serial transmitter
  assign tx_fire = i_air_rx_valid && tx_ready && !s_q.sleep;

  rmul_tx #(
    .BIT_CYC (BIT_CYC)
  ) u_tx (
    .i_ref_clk (i_ref_clk),
    .i_rst_b   (rst_b),
    .i_valid   (tx_fire),
    .i_data    (i_air_rx_data),
    .o_ready   (tx_ready),
    .o_txd     (o_txd)
  );

  assign o_air_tx_valid      = s_q.airv;
  assign o_air_tx_data       = s_q.aird;
  assign o_air_tx_last       = s_q.airl;
  assign o_pairing_indicator = s_q.lamp;
  assign o_sleep             = s_q.sleep;

  a_send_after_nl : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    o_air_tx_valid |-> (s_q.drain || o_air_tx_last || $past(s_q.drain)))
    else $error("byte sent before newline");
  // an accepted newline starts the send two edges later, even mid-drain
  a_send_on_nl : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (byte_ok && s_q.rsh == rmul_pkg::NEWLINE_CHAR && s_q.cnt != (AW+1)'(DEPTH)
      && !i_radio_wake_reset) |=> ##1 o_air_tx_valid)
    else $error("newline did not start sending");
  a_paired_steady : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (s_q.pst == RMUL_PR_PAIRED) |=> (o_pairing_indicator || !i_air_paired))
    else $error("indicator not steady while paired");
  a_sleep_holds : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (o_sleep && !i_radio_wake_reset) |=> o_sleep)
    else $error("left sleep without wake reset");
  a_wake_resume : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    i_radio_wake_reset |=> !o_sleep)
    else $error("wake reset did not resume");
  a_sleep_dark : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    o_sleep |-> !o_pairing_indicator)
    else $error("indicator lit in sleep");
  a_blink_waits : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (s_q.pst == RMUL_PR_WAIT && s_q.bcnt != 32'h0 && !i_air_paired && !i_radio_wake_reset
      && $stable(s_q.wcnt) == 1'b0) |-> $stable(o_pairing_indicator))
    else $error("indicator toggled early");
  a_queue_bound : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    s_q.cnt <= (AW+1)'(DEPTH))
    else $error("queue overfilled");
  a_idle_line : assert property (@(posedge i_ref_clk) disable iff (!rst_b)
    (tx_ready && !tx_fire) |=> o_txd)
    else $error("line not idle high");
endmodule // rmul_radio
`default_nettype wire

// [dv/rmul_host_model.sv]
// logic-side serial partner: sends characters to the radio and decodes its replies
`timescale 1ns/10ps
`default_nettype none
module rmul_host_model #(
  parameter int unsigned BIT_CYC = 16  // cycles per bit, shortened for simulation
) (
  input  wire logic i_ref_clk,  // reference clock
  input  wire logic i_line,     // serial from the radio
  output var  logic o_line      // serial to the radio
);
  logic [7:0] rx_q[$];     // bytes decoded from the radio
  int         frame_errs;  // frames whose stop bit was low
  logic [7:0] rx_b;        // byte being decoded

  // line idles high from time zero so no false start bit reaches the radio
  initial o_line = 1'b1;

  // one 8n1 character, lsb first, each bit held a full bit time after an edge
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge i_ref_clk);
      #1 o_line = frame[i];
      repeat (BIT_CYC - 1) @(posedge i_ref_clk);
    end
  endtask

  // receiver: mid-bit sampling after the falling start edge
  initial begin
    frame_errs = 0;
    forever begin
      @(negedge i_line);
      repeat (BIT_CYC / 2) @(posedge i_ref_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge i_ref_clk);
        rx_b[i] = i_line;
      end
      repeat (BIT_CYC) @(posedge i_ref_clk);
      if (i_line === 1'b1) begin
        rx_q.push_back(rx_b);
      end else begin
        frame_errs++;  // a low stop bit is a framing fault
      end
    end
  end
endmodule  // rmul_host_model
`default_nettype wire

// [dv/rmul_tb.sv]
// self-checking bench for the radio end of the serial link
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int unsigned BIT  = 16;    // short bit time keeps the run brief
  localparam int unsigned BLNK = 50;    // short blink half period
  localparam int unsigned WAIT = 2000;  // short pairing window
  logic       clk;               // reference clock
  logic       rst_b;             // reset, active low
  logic       wake;              // wake button
  logic       rxd;               // serial into the radio
  logic       paired;            // peer paired level
  logic       air_v;             // air byte strobe
  logic [7:0] air_b;             // air byte
  logic       txd;               // serial out of the radio
  logic       tx_v;              // air send strobe
  logic [7:0] tx_d;              // air send byte
  logic       tx_l;              // air send last flag
  logic       lamp;              // pairing lamp
  logic       slp;               // deep sleep
  logic [7:0] air_d[$];          // bytes seen leaving over the air
  logic       air_l[$];          // their last flags
  int         bad_count;         // mismatches
  int         total_checks;      // comparisons made
  int         cyc;               // cycles since start, for the hang limit
  int         tg;                // toggle count scratch

  rmul_radio #(.BIT_CYC(BIT), .BLINK_CYC(BLNK), .WAIT_CYC(64'(WAIT)), .DEPTH(256)) u_dut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_radio_wake_reset(wake), .i_rxd(rxd),
    .i_air_paired(paired), .i_air_rx_valid(air_v), .i_air_rx_data(air_b),
    .o_txd(txd), .o_air_tx_valid(tx_v), .o_air_tx_data(tx_d), .o_air_tx_last(tx_l),
    .o_pairing_indicator(lamp), .o_sleep(slp));
  rmul_host_model #(.BIT_CYC(BIT)) u_host (.i_ref_clk(clk), .i_line(txd), .o_line(rxd));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // collect air output; registered outputs are stable at the edge
  always @(posedge clk) begin
    if (tx_v === 1'b1) begin
      air_d.push_back(tx_d);
      air_l.push_back(tx_l);
    end
    cyc++;
    if (cyc == 90000) begin
      $display("BAD %0t run did not finish in time", $time);
      bad_count++;
      end_sim();
    end
  end

  task automatic chk_bit(input logic got, input logic exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one fewer than the fewest lamp toggles a blinking lamp shows over a window
  function automatic int min_toggles(input int win);
    return win / int'(BLNK) - 1;
  endfunction
  task automatic count_toggles(input int win, output int n);
    logic prev;
    n = 0;
    prev = lamp;
    repeat (win) begin
      tick(1);
      if (lamp !== prev) n++;
      prev = lamp;
    end
  endtask
  // n random payload bytes and a newline; nothing may leave before the newline
  task automatic send_pkt(input int n, input logic expect_out);
    logic [7:0] exp[$];
    logic [7:0] b;
    air_d = {};
    air_l = {};
    for (int i = 0; i < n; i++) begin
      b = 8'($urandom_range(0, 255));
      if (b == rmul_pkg::NEWLINE_CHAR) b = 8'h0b;
      exp.push_back(b);
      u_host.send_byte(b);
    end
    tick(BIT);
    chk_word(16'(air_d.size()), 16'h0000, "early air bytes");
    u_host.send_byte(rmul_pkg::NEWLINE_CHAR);
    exp.push_back(rmul_pkg::NEWLINE_CHAR);
    tick(n + 8);
    chk_word(16'(air_d.size()), expect_out ? 16'(n + 1) : 16'h0000, "air count");
    for (int i = 0; i < air_d.size() && i <= n; i++) begin
      chk_word({8'h00, air_d[i]}, {8'h00, exp[i]}, "air byte");
      chk_bit(air_l[i], 1'(i == n), "last flag");
    end
  endtask

  initial begin
    bad_count = 0;
    total_checks = 0;
    cyc = 0;
    rst_b = 1'b0;
    wake = 1'b0;
    paired = 1'b0;
    air_v = 1'b0;
    air_b = 8'h00;
    void'($urandom(32'h537ab7b0));
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    tick(4);
    count_toggles(4 * BLNK, tg);
    chk_bit(1'(tg >= min_toggles(4 * BLNK)), 1'b1, "lamp blinks");
    paired = 1'b1;
    tick(4);
    count_toggles(4 * BLNK, tg);
    chk_word(16'(tg), 16'h0000, "lamp toggles when paired");
    chk_bit(lamp, 1'b1, "lamp steady on");
    send_pkt(0, 1'b1);
    for (int k = 0; k < 3; k++) send_pkt($urandom_range(1, 30), 1'b1);
    send_pkt(255, 1'b1);
    for (int k = 0; k < 6; k++) begin
      air_b = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($urandom_range(0, 255));
      air_v = 1'b1;
      tick(1);
      air_v = 1'b0;
      tick(11 * BIT + 4);
      chk_word(16'(u_host.rx_q.size()), 16'h0001, "serial count");
      if (u_host.rx_q.size() > 0) begin
        chk_word({8'h00, u_host.rx_q.pop_front()}, {8'h00, air_b}, "serial byte");
      end
    end
    chk_word(16'(u_host.frame_errs), 16'h0000, "stop bits");
    paired = 1'b0;
    tick(WAIT / 2);
    chk_bit(slp, 1'b0, "asleep too soon");
    tick(WAIT / 2 + 100);
    chk_bit(slp, 1'b1, "sleep after window");
    chk_bit(lamp, 1'b0, "lamp off asleep");
    send_pkt(2, 1'b0);
    chk_bit(slp, 1'b1, "stays asleep");
    // a byte from the air while asleep must not reach the serial line
    air_b = 8'($urandom_range(0, 255));
    air_v = 1'b1;
    tick(1);
    air_v = 1'b0;
    tick(11 * BIT + 4);
    chk_word(16'(u_host.rx_q.size()), 16'h0000, "serial out asleep");
    wake = 1'b1;
    tick(2);
    wake = 1'b0;
    tick(4);
    chk_bit(slp, 1'b0, "woken");
    count_toggles(4 * BLNK, tg);
    chk_bit(1'(tg >= min_toggles(4 * BLNK)), 1'b1, "blinks after wake");
    end_sim();
  end

  task automatic end_sim();
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
endmodule  // testbench
`default_nettype wire
